// ===== src/if_pll_defs.vh
// Constants for the auxiliary-loop divider configuration words
`ifndef IF_PLL_DEFS_VH
`define IF_PLL_DEFS_VH
`define WORD_W 24
`define ADDR_HI 3
`define ADDR_IF_DIV 4'h5
`define ADDR_REF_GAIN 4'h7
`define ADDR_MAIN_FREQ 4'h0
`define AUX_LOOP_POWER_DOWN_BIT 23
`define IF_N_HI 22
`define IF_N_LO 4
`define IF_N_W 19
`define MASK_HI 23
`define MASK_LO 20
`define GAIN_HI 19
`define GAIN_LO 16
`define IF_R_HI 15
`define IF_R_LO 4
`define IF_R_W 12
`define SWALLOW_W_SMALL 3
`define SWALLOW_W_LARGE 4
`define MOD_SMALL 5'h08
`define MOD_LARGE 5'h10
`define MAIN_MIN 16'h0003
`define IF_R_MIN 12'h003
`define IF_N_RST 19'h00000
`define IF_R_RST 12'h000
`define GAIN_RST 4'h0
`define MASK_RST 4'h1
`define PD_RST 1'b1
`define MAIN_CNT_RST 16'h0000
`define SWALLOW_RST 4'h0
`define PUMP_STEP 5'h01
`define PUMP_MULT_RST 5'h01
`define PUMP_MULT_OFF 5'h00
`endif

// ===== src/serial_shifter.v
// Three-wire serial receiver: shifts bits on link clock rises, emits a word on enable rise
`timescale 1ns/1ns
module serial_shifter #(
    parameter WIDTH = 24
) (
    input wire clk_i,
    input wire arst_n_i,
    input wire sclk_i,
    input wire sdata_i,
    input wire sle_i,
    output reg [WIDTH-1:0] word_o,
    output reg word_vld_o
);
    reg [2:0] sclk_s_r;
    reg [1:0] sdata_s_r;
    reg [2:0] sle_s_r;
    reg [WIDTH-1:0] shift_r;
    wire sclk_rise;
    wire sle_rise;
    // First stage feeds only the second; edge detection looks at stages two and three
    assign sclk_rise = sclk_s_r[1] & ~sclk_s_r[2];
    assign sle_rise = sle_s_r[1] & ~sle_s_r[2];
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sclk_s_r <= 3'h0;
            sdata_s_r <= 2'h0;
            sle_s_r <= 3'h0;
            shift_r <= {WIDTH{1'b0}};
            word_o <= {WIDTH{1'b0}};
            word_vld_o <= 1'b0;
        end else begin
            sclk_s_r <= {sclk_s_r[1:0], sclk_i};
            sdata_s_r <= {sdata_s_r[0], sdata_i};
            sle_s_r <= {sle_s_r[1:0], sle_i};
            // Most significant bit first; only the last WIDTH bits before enable count
            if (sclk_rise && !sle_s_r[1]) begin
                shift_r <= {shift_r[WIDTH-2:0], sdata_s_r[1]};
            end
            word_vld_o <= sle_rise;
            if (sle_rise) begin
                word_o <= shift_r;
            end
        end
    end
endmodule

// ===== src/if_pll_divider_config_words.v
// Auxiliary-loop divider and reference/gain configuration words with power-down control
`timescale 1ns/1ns
`include "if_pll_defs.vh"
//
// Contract
// - Address 0101 loads aux power-down flag bit 23 and 19-bit divide bits 22:4.
// - Small prescaler: low bits swallow, upper bits main; main below three illegal.
// - Power-down flag 1 stops aux loop and floats its pump; 0 runs it.
// - Auto power-up plus main frequency word write clears power-down flag.
// - Chip enable low keeps aux loop powered down regardless of flag.
// - Address 0111 loads mask 23:20, pump gain 19:16, reference divide 15:4.
// - Pump magnitude is gain code plus one unit steps.
// - Gain code applies only in steady state, not during fast lock.
// - Prescaler select 0 picks small modulus, 1 picks large modulus.
// - Mask bit marks an optional word programmed; unmarked takes defaults. Code only stores the mask on optional_word_mask_o.
// - Chip enable low first, then auto power-up, then the flag.
module if_pll_divider_config_words (
    input wire clk_i,
    input wire arst_n_i,
    input wire sclk_i,
    input wire sdata_i,
    input wire sle_i,
    input wire chip_en_i,
    input wire auto_power_up_i,
    input wire prescaler_sel_i,
    input wire fastlock_active_i,
    output reg aux_loop_power_down_o,
    output reg aux_loop_enable_o,
    output reg aux_pump_drive_en_o,
    output reg [`IF_N_W-1:0] aux_divide_o,
    output reg [15:0] aux_main_count_o,
    output reg [3:0] aux_swallow_count_o,
    output reg [4:0] aux_modulus_o,
    output reg aux_divide_illegal_o,
    output reg [`IF_R_W-1:0] aux_ref_divide_o,
    output reg aux_ref_illegal_o,
    output reg [3:0] main_pump_gain_code_o,
    output reg [4:0] main_pump_multiple_o,
    output reg [3:0] optional_word_mask_o
);
    wire [`WORD_W-1:0] word;
    wire word_vld;
    reg [1:0] ce_s_r;
    reg [1:0] auto_power_up_s_r;
    reg [1:0] psel_s_r;
    reg [1:0] fl_s_r;
    reg [15:0] main_cnt;
    reg [3:0] swallow_cnt;
    reg [4:0] modulus;
    reg pd_flag_nxt;
    reg loop_on;
    wire [3:0] addr;

    serial_shifter #(
        .WIDTH(`WORD_W)
    ) u_rx (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .sclk_i(sclk_i),
        .sdata_i(sdata_i),
        .sle_i(sle_i),
        .word_o(word),
        .word_vld_o(word_vld)
    );

    assign addr = word[`ADDR_HI:0];

    // Split depends on the prescaler: 3 swallow bits for small, 4 for large
    always @* begin
        if (!psel_s_r[1]) begin
            modulus = `MOD_SMALL;
            swallow_cnt = {1'b0, aux_divide_o[`SWALLOW_W_SMALL-1:0]};
            main_cnt = aux_divide_o[`IF_N_W-1:`SWALLOW_W_SMALL];
        end else begin
            modulus = `MOD_LARGE;
            swallow_cnt = aux_divide_o[`SWALLOW_W_LARGE-1:0];
            main_cnt = {1'b0, aux_divide_o[`IF_N_W-1:`SWALLOW_W_LARGE]};
        end
    end

    // Flag update: a write and an auto power-up clear in one cycle; the clear wins
    // since auto power-up is meant to override whatever was last loaded
    always @* begin
        pd_flag_nxt = aux_loop_power_down_o;
        if (word_vld && addr == `ADDR_IF_DIV) begin
            pd_flag_nxt = word[`AUX_LOOP_POWER_DOWN_BIT];
        end
        if (word_vld && addr == `ADDR_MAIN_FREQ && auto_power_up_s_r[1]) begin
            pd_flag_nxt = 1'b0;
        end
    end

    // Precedence: chip enable, then auto power-up, then the flag
    always @* begin
        if (!ce_s_r[1]) begin
            loop_on = 1'b0;
        end else begin
            loop_on = ~pd_flag_nxt;
        end
    end

    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ce_s_r <= 2'h0;
            auto_power_up_s_r <= 2'h0;
            psel_s_r <= 2'h0;
            fl_s_r <= 2'h0;
            aux_loop_power_down_o <= `PD_RST;
            aux_loop_enable_o <= 1'b0;
            aux_pump_drive_en_o <= 1'b0;
            aux_divide_o <= `IF_N_RST;
            aux_main_count_o <= `MAIN_CNT_RST;
            aux_swallow_count_o <= `SWALLOW_RST;
            aux_modulus_o <= `MOD_SMALL;
            aux_divide_illegal_o <= 1'b1;
            aux_ref_divide_o <= `IF_R_RST;
            aux_ref_illegal_o <= 1'b1;
            main_pump_gain_code_o <= `GAIN_RST;
            main_pump_multiple_o <= `PUMP_MULT_RST;
            optional_word_mask_o <= `MASK_RST;
        end else begin
            ce_s_r <= {ce_s_r[0], chip_en_i};
            auto_power_up_s_r <= {auto_power_up_s_r[0], auto_power_up_i};
            psel_s_r <= {psel_s_r[0], prescaler_sel_i};
            fl_s_r <= {fl_s_r[0], fastlock_active_i};
            aux_loop_power_down_o <= pd_flag_nxt;
            aux_loop_enable_o <= loop_on;
            aux_pump_drive_en_o <= loop_on;
            if (word_vld && addr == `ADDR_IF_DIV) begin
                aux_divide_o <= word[`IF_N_HI:`IF_N_LO];
            end
            if (word_vld && addr == `ADDR_REF_GAIN) begin
                optional_word_mask_o <= word[`MASK_HI:`MASK_LO];
                main_pump_gain_code_o <= word[`GAIN_HI:`GAIN_LO];
                aux_ref_divide_o <= word[`IF_R_HI:`IF_R_LO];
            end
            aux_main_count_o <= main_cnt;
            aux_swallow_count_o <= swallow_cnt;
            aux_modulus_o <= modulus;
            // Flags main count below three for the host; hardware does not refuse it
            aux_divide_illegal_o <= (main_cnt < `MAIN_MIN);
            aux_ref_illegal_o <= (aux_ref_divide_o < `IF_R_MIN);
            // Fast lock uses its own current, so the multiple drops to zero then
            if (fl_s_r[1]) begin
                main_pump_multiple_o <= `PUMP_MULT_OFF;
            end else begin
                main_pump_multiple_o <= {1'b0, main_pump_gain_code_o} + `PUMP_STEP;
            end
        end
    end
endmodule

// ===== tb/host_link_model.sv
// Host side of the three-wire programming link
`timescale 1ns/1ns
module host_link_model (
    input logic clk_i,
    output logic sclk_o,
    output logic sdata_o,
    output logic sle_o
);
    initial begin
        sclk_o = 1'b0;
        sdata_o = 1'b0;
        sle_o = 1'b0;
    end
    // Link clock 160 ns: four system cycles high, four low
    task automatic send(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin
            @(negedge clk_i);
            sdata_o = w[i];
            repeat (3) @(negedge clk_i);
            sclk_o = 1'b1;
            repeat (4) @(negedge clk_i);
            sclk_o = 1'b0;
        end
        repeat (4) @(negedge clk_i);
        sle_o = 1'b1;
        repeat (8) @(negedge clk_i);
        sle_o = 1'b0;
        // Released data line carries no stale bit
        sdata_o = ~sdata_o;
        repeat (4) @(negedge clk_i);
    endtask
endmodule

// ===== tb/if_pll_divider_config_words_asserts.sv
// Port-level assertions for the auxiliary-loop configuration words
`timescale 1ns/1ns
module cfg_chk (
    input logic clk_i,
    input logic arst_n_i,
    input logic chip_en_i,
    input logic prescaler_sel_i,
    input logic fastlock_active_i,
    input logic aux_loop_power_down_o,
    input logic aux_loop_enable_o,
    input logic aux_pump_drive_en_o,
    input logic [18:0] aux_divide_o,
    input logic [15:0] aux_main_count_o,
    input logic [3:0] aux_swallow_count_o,
    input logic [4:0] aux_modulus_o,
    input logic aux_divide_illegal_o,
    input logic [11:0] aux_ref_divide_o,
    input logic aux_ref_illegal_o,
    input logic [3:0] main_pump_gain_code_o,
    input logic [4:0] main_pump_multiple_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    // Pins cross a synchroniser, so levels must be held before outputs follow
    sequence s_ce_low; !chip_en_i [*5]; endsequence
    sequence s_fl_on; fastlock_active_i [*5]; endsequence
    property p_ce_off; s_ce_low |-> !aux_loop_enable_o && !aux_pump_drive_en_o; endproperty
    property p_pd_off; aux_loop_power_down_o [*2] |-> !aux_loop_enable_o && !aux_pump_drive_en_o; endproperty
    property p_split; $stable(aux_divide_o) |->
        {16'h0000, aux_main_count_o} * aux_modulus_o + aux_swallow_count_o == aux_divide_o; endproperty
    property p_ill; $stable(aux_main_count_o) |-> aux_divide_illegal_o == (aux_main_count_o < 3); endproperty
    property p_ref_ill; $stable(aux_ref_divide_o) |-> aux_ref_illegal_o == (aux_ref_divide_o < 3); endproperty
    property p_fl; s_fl_on |-> main_pump_multiple_o == 5'h00; endproperty
    property p_mult; !fastlock_active_i [*5] ##0 $stable(main_pump_gain_code_o) |->
        main_pump_multiple_o == main_pump_gain_code_o + 1; endproperty
    property p_mod_lg; prescaler_sel_i [*5] |-> aux_modulus_o == 5'h10; endproperty
    property p_mod_sm; !prescaler_sel_i [*5] |-> aux_modulus_o == 5'h08; endproperty
    a_ce_off: assert property (p_ce_off) else $error("loop on with chip enable low");
    a_pd_off: assert property (p_pd_off) else $error("loop on while powered down");
    a_split: assert property (p_split) else $error("divide split wrong");
    a_ill: assert property (p_ill) else $error("divide flag wrong");
    a_ref_ill: assert property (p_ref_ill) else $error("reference flag wrong");
    a_fl: assert property (p_fl) else $error("gain used in fast lock");
    a_mult: assert property (p_mult) else $error("pump multiple wrong");
    a_mod_lg: assert property (p_mod_lg) else $error("modulus not 16");
    a_mod_sm: assert property (p_mod_sm) else $error("modulus not 8");
endmodule
bind if_pll_divider_config_words cfg_chk u_chk (.*);

// ===== tb/if_pll_divider_config_words_tb_top.sv
// Bench for the auxiliary-loop divider and reference/gain words
`timescale 1ns/1ns
module if_pll_divider_config_words_tb_top;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic chip_en_i = 1'b1;
    logic auto_power_up_i = 1'b0;
    logic prescaler_sel_i = 1'b0;
    logic fastlock_active_i = 1'b0;
    logic sclk_i;
    logic sdata_i;
    logic sle_i;
    logic aux_loop_power_down_o;
    logic aux_loop_enable_o;
    logic aux_pump_drive_en_o;
    logic aux_divide_illegal_o;
    logic aux_ref_illegal_o;
    logic [18:0] aux_divide_o;
    logic [15:0] aux_main_count_o;
    logic [3:0] aux_swallow_count_o;
    logic [4:0] aux_modulus_o;
    logic [11:0] aux_ref_divide_o;
    logic [3:0] main_pump_gain_code_o;
    logic [4:0] main_pump_multiple_o;
    logic [3:0] optional_word_mask_o;
    int n_fail = 0;
    int compares = 0;
    // Row: prescaler select, word, main count, swallow count
    logic [44:0] rows [4] = '{{1'b0, 1'b0, 19'h00018, 4'h5, 16'h0003, 4'h0},
        {1'b0, 1'b1, 19'h3ffff, 4'h5, 16'h7fff, 4'h7}, {1'b1, 1'b0, 19'h00030, 4'h5, 16'h0003, 4'h0},
        {1'b1, 1'b1, 19'h7ffff, 4'h5, 16'h7fff, 4'hf}};
    host_link_model host (.clk_i(clk_i), .sclk_o(sclk_i), .sdata_o(sdata_i), .sle_o(sle_i));
    if_pll_divider_config_words uut (.*);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial forever #10 clk_i = ~clk_i;
    initial begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        summarize();
    end
    initial begin
        repeat (12) @(negedge clk_i);
        arst_n_i = 1'b1;
        repeat (4) @(negedge clk_i);
        chk({aux_loop_power_down_o, aux_loop_enable_o, optional_word_mask_o}, 6'h21);
        foreach (rows[i]) begin
            prescaler_sel_i = rows[i][44];
            host.send(rows[i][43:20]);
            chk(aux_divide_o, rows[i][42:24]);
            chk(aux_loop_power_down_o, rows[i][43]);
            chk(aux_loop_enable_o, !rows[i][43]);
            chk(aux_pump_drive_en_o, !rows[i][43]);
            chk(aux_divide_illegal_o, 1'b0);
            chk(aux_main_count_o, rows[i][19:4]);
            chk(aux_swallow_count_o, rows[i][3:0]);
            chk(aux_modulus_o, rows[i][44] ? 5'h10 : 5'h08);
        end
        for (int k = 0; k < 16; k++) begin
            host.send({k[2:0], 1'b1, k[3:0], k[3:0], 8'h03, 4'h7});
            chk({main_pump_gain_code_o, aux_ref_divide_o}, {k[3:0], k[3:0], 8'h03});
            chk(main_pump_multiple_o, k + 1);
            chk(optional_word_mask_o, {k[2:0], 1'b1});
            chk(aux_ref_illegal_o, 1'b0);
        end
        auto_power_up_i = 1'b1;
        host.send(24'hfffff3);
        chk({aux_divide_o, aux_loop_power_down_o}, 20'hfffff);
        // Below-minimum values are stored but flagged for the host
        host.send({1'b1, 19'h0002f, 4'h5});
        host.send({4'h1, 4'hf, 12'h002, 4'h7});
        chk({aux_divide_illegal_o, aux_ref_illegal_o}, 2'h3);
        host.send(24'h000000);
        chk({aux_loop_power_down_o, aux_loop_enable_o}, 2'h1);
        chip_en_i = 1'b0;
        fastlock_active_i = 1'b1;
        repeat (6) @(negedge clk_i);
        chk({aux_loop_enable_o, aux_pump_drive_en_o}, 2'h0);
        chk(main_pump_multiple_o, 5'h00);
        chip_en_i = 1'b1;
        fastlock_active_i = 1'b0;
        repeat (6) @(negedge clk_i);
        chk({aux_loop_enable_o, main_pump_multiple_o}, 6'h30);
        arst_n_i = 1'b0;
        repeat (3) @(negedge clk_i);
        arst_n_i = 1'b1;
        repeat (4) @(negedge clk_i);
        chk({aux_loop_power_down_o, aux_loop_enable_o, optional_word_mask_o}, 6'h21);
        summarize();
    end
endmodule
